// [rtl/tsc_regs.svh]
/*
 * register map, field positions, reset values, timing and scale constants of the tunable
 * source control register group.
 * assumes: included by its bare name from the design and testbench files.
 */
`ifndef TSC_REGS_SVH
`define TSC_REGS_SVH

// ----------------------------------------------------------------------
// register offsets (16-bit words on the management link)
// ----------------------------------------------------------------------
`define TSC_OFS_STATUS_FATAL  8'h20
`define TSC_OFS_STATUS_WARN   8'h21
`define TSC_OFS_FATAL_TRIG    8'h29
`define TSC_OFS_ALARM_TRIG    8'h2a
`define TSC_OFS_CHANNEL       8'h30
`define TSC_OFS_POWER_SET     8'h31
`define TSC_OFS_RESET_CTL     8'h32
`define TSC_OFS_CONFIG        8'h33
`define TSC_OFS_SPACING       8'h34
`define TSC_OFS_FIRST_HI      8'h35
`define TSC_OFS_FIRST_LO      8'h36
`define TSC_OFS_FREQ_HI       8'h40
`define TSC_OFS_FREQ_LO       8'h41

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define TSC_RST_ALARM_TRIG    16'h0404
`define TSC_RST_FATAL_TRIG    16'h000f
`define TSC_RST_CONFIG        16'h0002
`define TSC_RST_ZERO          16'h0000
`define TSC_RST_CHANNEL       16'h0001

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define TSC_CFG_RESTORE       0
`define TSC_CFG_ALARM_TUNE    1
`define TSC_CFG_SHUTDOWN      2
`define TSC_CFG_SW_ENABLE     3
`define TSC_CFG_REPORT_CUR    4
`define TSC_RST_MODULE_BIT    0
`define TSC_RST_SOFT_BIT      1
`define TSC_ST_HW_OFF         12
`define TSC_ST_RUN_FAULT      7
`define TSC_ST_COMM_ERR       6
`define TSC_ST_LATCH_LO       0
`define TSC_ST_LATCH_HI       3
`define TSC_ST_LIVE_LO        8

// ----------------------------------------------------------------------
// widths and timing
// ----------------------------------------------------------------------
`define TSC_TUNE_CYCLES       16'h0010
`define TSC_FREQ_UNIT_DIV     32'h0000_0001
`define TSC_FREQ_HI_SCALE     32'h0000_2710

`endif

// [rtl/tsc_pkg.sv]
/*
 * types shared by the tunable source control design.
 * assumes: constants come from tsc_regs.svh.
 */
package tsc_pkg;
   // tuning sequencer states, one-hot
   typedef enum logic [2:0] {
      TSC_IDLE   = 3'b001,
      TSC_TUNE   = 3'b010,
      TSC_LOCKED = 3'b100
   } tsc_tune_e;

   typedef logic [15:0] tsc_word_t;
endpackage

// [rtl/tsc_freq_calc.sv]
/*
 * target frequency calculator: (channel - 1) * spacing + first channel.
 * frequency is expressed in units of 100 MHz, signed 32 bit.
 * assumes: operands stable for the cycle they are sampled; output registered.
 */
`timescale 1ns/1ps
`include "tsc_regs.svh"
module tsc_freq_calc (
   input  wire logic              clk,
   input  wire logic              arst_n,
   input  wire logic [15:0]       channel,
   input  wire logic [15:0]       spacing,
   input  wire logic [15:0]       first_hi,
   input  wire logic [15:0]       first_lo,
   output logic [31:0]            freq_ff
);
   import tsc_pkg::*;

   logic signed [31:0] nxt_freq;   // combinational target
   logic signed [31:0] first_100m; // first channel in 100 MHz steps
   logic signed [31:0] step_sum;   // signed channel offset product

   // ------------------------------------------------------------------
   // arithmetic
   // ------------------------------------------------------------------
   // high word is thz*1000 GHz, low word tenths of GHz; 100 MHz == 0.1 GHz
   always_comb begin
      first_100m = $signed({16'h0000, first_hi}) * $signed(`TSC_FREQ_HI_SCALE)
                 + $signed({16'h0000, first_lo});
      step_sum   = $signed({16'h0000, channel} - 32'h0000_0001)
                 * $signed({{16{spacing[15]}}, spacing});
      nxt_freq   = step_sum + first_100m;
   end

   // registered result keeps the top output straight from a flop
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         freq_ff <= 32'h0000_0000;
      end else begin
         freq_ff <= nxt_freq;
      end
   end
endmodule // tsc_freq_calc

// [rtl/tsc_ctrl_regs.sv]
/*
 * control register group of a tunable optical source: alarm trigger mask,
 * channel select with frequency derivation, power set point, self-clearing
 * resets, module configuration, grid spacing and first-channel frequency.
 * assumes: a management link front end delivers decoded word writes and
 * reads (wr_en/rd_en with 8-bit address) synchronous to clk; live status
 * flags and capability limits come from the optics controller.
 */
// Notes on behaviour
// - alarm line low when masked flag set
// - mask rewrite releases alarm at once
// - bad channel write ignored, raises run fault
// - frequency from channel, spacing, first channel
// - channel write tunes only when enabled
// - pin rising alone never starts tuning
// - output off by fatal, software or hardware
// - hardware off latched, cleared by software enable
// - output undefined after run fault
// - power write updates when locked, unmet power faults
// - module reset bit self-clears, resets all
// - soft reset self-clears, faults if unsupported
// - soft reset and deselect reset link
// - restore bit keeps state over resets; here only stored, arst_n resets all
// - alarm during tuning and while disabled
// - shutdown-on-fatal bit gates fatal term
// - light only with enable and pin high
// - report bit selects error flag policy
// - report bit default from latched mode pins
// - spacing write while enabled faults
// - first-channel write while enabled faults
// - unsupported spacing or frequency faults
// - write one clears latched flags
// - fatal trigger mask resets to 0x000F
`timescale 1ns/1ps
`include "tsc_regs.svh"
module tsc_ctrl_regs #(
   parameter logic        SOFT_RESET_OK = 1'b1,  // device supports soft reset
   parameter logic [15:0] CHAN_MAX      = 16'h0064, // highest valid channel
   parameter logic [15:0] SPACING_MIN   = 16'h0001, // smallest |spacing|
   parameter logic [15:0] FIRST_HI_MIN  = 16'h00be, // lowest first-channel hi word
   parameter logic [15:0] FIRST_HI_MAX  = 16'h00c4  // highest first-channel hi word
) (
   input  wire logic              clk,
   input  wire logic              arst_n,
   input  wire logic              wr_en,
   input  wire logic              rd_en,
   input  wire logic [7:0]        addr,
   input  wire logic [15:0]       wdata,
   input  wire logic              cmd_pending,
   input  wire logic              comm_fault,
   input  wire logic [3:0]        fatal_live,
   input  wire logic [3:0]        warn_live,
   input  wire logic              power_unmet,
   input  wire logic              pending_fail,
   input  wire logic              module_select_pin,
   input  wire logic              hw_output_off_pin,
   input  wire logic              interface_select_pin_a,
   input  wire logic              interface_select_pin_b,
   output logic [15:0]            rdata_ff,
   output logic                   rvalid_ff,
   output logic                   lock_alarm_line_n_ff,
   output logic                   output_enable_ff,
   output logic                   tune_start_ff,
   output logic                   power_update_ff,
   output logic                   module_reset_ff,
   output logic                   link_reset_ff,
   output logic [31:0]            target_freq_ff
);
   import tsc_pkg::*;

   // ------------------------------------------------------------------
   // storage
   // ------------------------------------------------------------------
   tsc_word_t  alarm_trig_ff;   // lock_alarm_trigger_mask
   tsc_word_t  fatal_trig_ff;   // fatal trigger mask (disable equation)
   tsc_word_t  channel_ff;      // channel_select
   tsc_word_t  power_ff;        // power_set_point
   tsc_word_t  reset_ctl_ff;    // module_reset_control, self-clearing
   tsc_word_t  config_ff;       // module_behaviour_config
   tsc_word_t  spacing_ff;      // channel_spacing
   tsc_word_t  first_hi_ff;     // first_channel_freq_high
   tsc_word_t  first_lo_ff;     // first_channel_freq_low
   logic [3:0] fatal_lat_ff;    // latched fatal indicators
   logic [3:0] warn_lat_ff;     // latched warning indicators
   logic       hw_off_latched_ff; // latched hardware disable
   logic       run_fault_flag_ff; // execution error
   logic       comm_error_flag_ff;
   logic       strap_done_ff;   // mode pins captured after release
   tsc_tune_e  tune_ff;         // tuning sequencer
   logic [15:0] tune_cnt_ff;    // tuning settle counter
   logic       deselect_q_ff;   // previous select level

   logic       out_enabled;     // combinational output-enable
   logic       fatal_term;
   logic       run_fault_set;   // command raised an execution error
   logic       wr_chan_ok;
   logic       w_alarm, w_fatal, w_chan, w_pwr, w_rst, w_cfg, w_spc, w_fhi, w_flo;
   logic       w_stf, w_stw;
   logic       sw_en_rise;
   logic [15:0] status_fatal;   // assembled status word
   logic [15:0] status_warn;
   logic [31:0] calc_freq;

   // one decode used by every write strobe
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   assign w_alarm = wr_en && hit(addr, `TSC_OFS_ALARM_TRIG);
   assign w_fatal = wr_en && hit(addr, `TSC_OFS_FATAL_TRIG);
   assign w_chan  = wr_en && hit(addr, `TSC_OFS_CHANNEL);
   assign w_pwr   = wr_en && hit(addr, `TSC_OFS_POWER_SET);
   assign w_rst   = wr_en && hit(addr, `TSC_OFS_RESET_CTL);
   assign w_cfg   = wr_en && hit(addr, `TSC_OFS_CONFIG);
   assign w_spc   = wr_en && hit(addr, `TSC_OFS_SPACING);
   assign w_fhi   = wr_en && hit(addr, `TSC_OFS_FIRST_HI);
   assign w_flo   = wr_en && hit(addr, `TSC_OFS_FIRST_LO);
   assign w_stf   = wr_en && hit(addr, `TSC_OFS_STATUS_FATAL);
   assign w_stw   = wr_en && hit(addr, `TSC_OFS_STATUS_WARN);

   // ------------------------------------------------------------------
   // command checks
   // ------------------------------------------------------------------
   assign wr_chan_ok  = (wdata != 16'h0000) && (wdata <= CHAN_MAX);
   assign fatal_term  = |({12'h000, fatal_lat_ff} & fatal_trig_ff)
                      & config_ff[`TSC_CFG_SHUTDOWN];
   // off when fatal term, software enable clear or pin latch set
   assign out_enabled = !fatal_term && config_ff[`TSC_CFG_SW_ENABLE]
                      && !hw_off_latched_ff;
   assign sw_en_rise  = w_cfg && wdata[`TSC_CFG_SW_ENABLE]
                      && (!config_ff[`TSC_CFG_SW_ENABLE] || hw_off_latched_ff);

   // every way a command can fail
   always_comb begin
      run_fault_set = 1'b0;
      if (w_chan && !wr_chan_ok) begin
         run_fault_set = 1'b1;
      end
      if ((w_spc || w_fhi || w_flo) && out_enabled) begin
         run_fault_set = 1'b1;
      end
      if (w_spc && (wdata == 16'h0000 ||
          ((wdata[15] ? (16'h0000 - wdata) : wdata) < SPACING_MIN))) begin
         run_fault_set = 1'b1;
      end
      if (w_fhi && (wdata < FIRST_HI_MIN || wdata > FIRST_HI_MAX)) begin
         run_fault_set = 1'b1;
      end
      if (w_pwr && power_unmet) begin
         run_fault_set = 1'b1;
      end
      if (w_rst && wdata[`TSC_RST_SOFT_BIT] && !SOFT_RESET_OK) begin
         run_fault_set = 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // trigger masks
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         alarm_trig_ff <= `TSC_RST_ALARM_TRIG;
         fatal_trig_ff <= `TSC_RST_FATAL_TRIG;
      end else begin
         if (w_alarm) begin
            alarm_trig_ff <= wdata;
         end
         if (w_fatal) begin
            fatal_trig_ff <= wdata;
         end
      end
   end

   // ------------------------------------------------------------------
   // tuning parameters; writes refused while enabled leave value intact
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         channel_ff  <= `TSC_RST_CHANNEL;
         power_ff    <= `TSC_RST_ZERO;
         spacing_ff  <= `TSC_RST_ZERO;
         first_hi_ff <= `TSC_RST_ZERO;
         first_lo_ff <= `TSC_RST_ZERO;
      end else begin
         if (w_chan && wr_chan_ok) begin
            channel_ff <= wdata;
         end
         if (w_pwr) begin
            power_ff <= wdata;
         end
         if (w_spc && !run_fault_set) begin
            spacing_ff <= wdata;
         end
         if (w_fhi && !run_fault_set) begin
            first_hi_ff <= wdata;
         end
         if (w_flo && !out_enabled) begin
            first_lo_ff <= wdata;
         end
      end
   end

   // ------------------------------------------------------------------
   // configuration; report-bit default caught from mode pins after release
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         config_ff     <= `TSC_RST_CONFIG;
         strap_done_ff <= 1'b0;
      end else begin
         strap_done_ff <= 1'b1;
         if (!strap_done_ff) begin
            // spi and i2c (pin a low) report, others do not
            config_ff[`TSC_CFG_REPORT_CUR] <= !interface_select_pin_a;
         end else if (w_cfg) begin
            config_ff <= {11'h000, wdata[4:0]};
         end
      end
   end

   // ------------------------------------------------------------------
   // hardware disable latch: set by pin low, cleared only by enable write
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hw_off_latched_ff <= 1'b1;
      end else begin
         if (!hw_output_off_pin) begin
            hw_off_latched_ff <= 1'b1; // set wins
         end else if (w_cfg && wdata[`TSC_CFG_SW_ENABLE]) begin
            hw_off_latched_ff <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // status latches and error flags; event sets win over write-one clears
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fatal_lat_ff       <= 4'h0;
         warn_lat_ff        <= 4'h0;
         run_fault_flag_ff  <= 1'b0;
         comm_error_flag_ff <= 1'b0;
      end else begin
         fatal_lat_ff <= fatal_live | (fatal_lat_ff & ~(w_stf ? wdata[3:0] : 4'h0));
         warn_lat_ff  <= warn_live  | (warn_lat_ff  & ~(w_stw ? wdata[3:0] : 4'h0));
         if ((run_fault_set && config_ff[`TSC_CFG_REPORT_CUR]) || pending_fail) begin
            run_fault_flag_ff <= 1'b1;
         end else if (w_stf && wdata[`TSC_ST_RUN_FAULT]) begin
            run_fault_flag_ff <= 1'b0;
         end
         if (comm_fault && config_ff[`TSC_CFG_REPORT_CUR]) begin
            comm_error_flag_ff <= 1'b1;
         end else if (w_stf && wdata[`TSC_ST_COMM_ERR]) begin
            comm_error_flag_ff <= 1'b0;
         end
      end
   end

   assign status_fatal = {3'b000, hw_off_latched_ff, warn_live, run_fault_flag_ff,
                          comm_error_flag_ff, 2'b00, fatal_lat_ff};
   assign status_warn  = {3'b000, hw_off_latched_ff, warn_live, run_fault_flag_ff,
                          comm_error_flag_ff, 2'b00, warn_lat_ff};

   // ------------------------------------------------------------------
   // resets: bits self-clear the cycle after the write
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         reset_ctl_ff    <= `TSC_RST_ZERO;
         module_reset_ff <= 1'b0;
         link_reset_ff   <= 1'b0;
         deselect_q_ff   <= 1'b0;
      end else begin
         deselect_q_ff   <= module_select_pin;
         reset_ctl_ff    <= `TSC_RST_ZERO; // self-clear
         module_reset_ff <= w_rst && wdata[`TSC_RST_MODULE_BIT];
         // soft reset or deselect edge resets the link front end
         link_reset_ff   <= (w_rst && wdata[`TSC_RST_SOFT_BIT] && SOFT_RESET_OK)
                          || (deselect_q_ff && !module_select_pin);
      end
   end

   // ------------------------------------------------------------------
   // tuning sequencer
   // ------------------------------------------------------------------
   // pin rising never starts a tune; only channel write or enable set
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tune_ff       <= TSC_IDLE;
         tune_cnt_ff   <= 16'h0000;
         tune_start_ff <= 1'b0;
      end else begin
         tune_start_ff <= 1'b0;
         case (tune_ff)
            TSC_IDLE, TSC_LOCKED: begin
               if ((w_chan && wr_chan_ok && out_enabled) ||
                   (sw_en_rise && hw_output_off_pin && !fatal_term)) begin
                  tune_ff       <= TSC_TUNE;
                  tune_cnt_ff   <= `TSC_TUNE_CYCLES;
                  tune_start_ff <= 1'b1;
               end else if (!out_enabled) begin
                  tune_ff <= TSC_IDLE;
               end
            end
            TSC_TUNE: begin
               if (w_chan && wr_chan_ok && out_enabled) begin
                  tune_cnt_ff   <= `TSC_TUNE_CYCLES; // new channel retunes
                  tune_start_ff <= 1'b1;
               end else if (!out_enabled) begin
                  tune_ff <= TSC_IDLE;
               end else if (tune_cnt_ff == 16'h0000 && !cmd_pending) begin
                  tune_ff <= TSC_LOCKED;
               end else if (tune_cnt_ff != 16'h0000) begin
                  tune_cnt_ff <= tune_cnt_ff - 16'h0001;
               end
            end
            default: begin
               tune_ff <= TSC_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // output flops: enable, power update, alarm line
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         output_enable_ff     <= 1'b0;
         power_update_ff      <= 1'b0;
         lock_alarm_line_n_ff <= 1'b1;
      end else begin
         output_enable_ff <= out_enabled;
         power_update_ff  <= w_pwr && !power_unmet && tune_ff == TSC_LOCKED;
         // next-state mask so a rewrite releases on the following edge
         lock_alarm_line_n_ff <= !((|(status_fatal & (w_alarm ? wdata : alarm_trig_ff)))
                                || (config_ff[`TSC_CFG_ALARM_TUNE]
                                    && (tune_ff != TSC_LOCKED)));
      end
   end

   // ------------------------------------------------------------------
   // read port: one-cycle answer, unmapped reads zero
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_ff  <= 16'h0000;
         rvalid_ff <= 1'b0;
      end else begin
         rvalid_ff <= rd_en;
         if (rd_en) begin
            case (addr)
               `TSC_OFS_STATUS_FATAL: rdata_ff <= status_fatal;
               `TSC_OFS_STATUS_WARN:  rdata_ff <= status_warn;
               `TSC_OFS_FATAL_TRIG:   rdata_ff <= fatal_trig_ff;
               `TSC_OFS_ALARM_TRIG:   rdata_ff <= alarm_trig_ff;
               `TSC_OFS_CHANNEL:      rdata_ff <= channel_ff;
               `TSC_OFS_POWER_SET:    rdata_ff <= power_ff;
               `TSC_OFS_RESET_CTL:    rdata_ff <= reset_ctl_ff;
               `TSC_OFS_CONFIG:       rdata_ff <= config_ff;
               `TSC_OFS_SPACING:      rdata_ff <= spacing_ff;
               `TSC_OFS_FIRST_HI:     rdata_ff <= first_hi_ff;
               `TSC_OFS_FIRST_LO:     rdata_ff <= first_lo_ff;
               default:               rdata_ff <= 16'h0000;
            endcase
         end
      end
   end

   // frequency target follows the calculator while tuning; spacing and
   // first-channel words are refused while enabled, so they cannot move it
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         target_freq_ff <= 32'h0000_0000;
      end else if (tune_ff == TSC_TUNE) begin
         target_freq_ff <= calc_freq;
      end
   end

   tsc_freq_calc u_freq (
      .clk      (clk),
      .arst_n   (arst_n),
      .channel  (channel_ff),
      .spacing  (spacing_ff),
      .first_hi (first_hi_ff),
      .first_lo (first_lo_ff),
      .freq_ff  (calc_freq)
   );
endmodule // tsc_ctrl_regs

// [tb/tsc_host.sv]
/* host model on the register link: word writes and reads.
   assumes: one clk; requests change at the falling edge. */
`timescale 1ns/1ps
module tsc_host (
   input  wire logic        clk,
   output logic             wr_en = 1'b0,
   output logic             rd_en = 1'b0,
   output logic [7:0]       addr  = 8'h00,
   output logic [15:0]      wdata = 16'h0000
);
   logic [15:0] q[$];  // expected read words, oldest first
   // one write cycle; data inverted once released so no stale value lingers
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge clk);
      wr_en = 1'b1;
      addr  = a;
      wdata = d;
      @(negedge clk);
      wr_en = 1'b0;
      wdata = ~d;
   endtask
   // one read cycle; the expected word is queued here for the read monitor
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(negedge clk);
      rd_en = 1'b1;
      addr  = a;
      q.push_back(e);
      @(negedge clk);
      rd_en = 1'b0;
   endtask
endmodule // tsc_host

// [tb/tsc_ctrl_regs_properties.sv]
/* port checker of the control register group.
   assumes: bound to tsc_ctrl_regs, single clk, arst_n active low. */
`timescale 1ns/1ps
`include "tsc_regs.svh"
module tsc_ctrl_regs_properties (
   input wire logic        clk, arst_n, wr_en, rd_en, hw_output_off_pin, module_select_pin,
   input wire logic [7:0]  addr,
   input wire logic [15:0] wdata,
   input wire logic        rvalid_ff, output_enable_ff, tune_start_ff, module_reset_ff,
   input wire logic        link_reset_ff
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   wire logic cfg_wr = wr_en && addr == `TSC_OFS_CONFIG;     // config word write
   wire logic rst_wr = wr_en && addr == `TSC_OFS_RESET_CTL;  // reset word write
   read_answer_a: assert property (rd_en |=> rvalid_ff)
      else $error("read not answered");
   sw_output_enable_off_a: assert property (cfg_wr && !wdata[3] |=> ##1 !output_enable_ff)
      else $error("output on without software enable");
   pin_off_a: assert property (!hw_output_off_pin [*3] |-> !output_enable_ff)
      else $error("output on with pin low");
   pin_rise_a: assert property ($rose(hw_output_off_pin) && !output_enable_ff && !wr_en
      |=> !output_enable_ff)
      else $error("pin rise enabled output");
   chan_zero_a: assert property (wr_en && addr == `TSC_OFS_CHANNEL && wdata == 16'h0000
      |=> !tune_start_ff)
      else $error("channel zero tuned");
   tune_en_a: assert property (tune_start_ff |=> output_enable_ff)
      else $error("tune while disabled");
   hard_reset_a: assert property (rst_wr && wdata[0] |=> module_reset_ff)
      else $error("module reset missing");
   soft_reset_a: assert property (rst_wr && wdata[1] |=> link_reset_ff)
      else $error("soft reset missing");
   deselect_a: assert property ($fell(module_select_pin) |-> ##[0:3] link_reset_ff)
      else $error("deselect kept link");
   cover property (tune_start_ff);
   cover property (rvalid_ff);
   cover property (module_reset_ff);
endmodule // tsc_ctrl_regs_properties
bind tsc_ctrl_regs tsc_ctrl_regs_properties chk (.clk, .arst_n, .wr_en, .rd_en,
   .hw_output_off_pin, .module_select_pin, .addr, .wdata, .rvalid_ff, .output_enable_ff,
   .tune_start_ff, .module_reset_ff, .link_reset_ff);

// [tb/test_tsc_ctrl_regs.sv]
/* self-checking bench of the control register group.
   assumes: tsc_host drives the link; read words checked by a monitor. */
`timescale 1ns/1ps
`include "tsc_regs.svh"
module test_tsc_ctrl_regs;
   import tsc_pkg::*;
   logic        clk = 0, arst_n = 0, pin_a = 0, pin_b = 0, hw_pin = 1, sel = 1;
   logic [3:0]  fatal = 4'h0;
   logic        wr_en, rd_en, rvalid, oe, tune, lock_n, pwr_up;
   logic [7:0]  addr;
   tsc_word_t   wdata, rdata;
   logic [31:0] freq, ef;
   logic [15:0] rs = 16'h000f;  // xorshift state
   int          n_errors = 0, compares = 0, ch;
   initial forever #12.5 clk = ~clk;
   tsc_host h (.clk, .wr_en, .rd_en, .addr, .wdata);
   tsc_ctrl_regs uut (.clk, .arst_n, .wr_en, .rd_en, .addr, .wdata, .cmd_pending(1'b0),
      .comm_fault(1'b0), .fatal_live(fatal), .warn_live(4'h0), .power_unmet(1'b0),
      .pending_fail(1'b0), .module_select_pin(sel), .hw_output_off_pin(hw_pin),
      .interface_select_pin_a(pin_a), .interface_select_pin_b(pin_b), .rdata_ff(rdata),
      .rvalid_ff(rvalid), .lock_alarm_line_n_ff(lock_n), .output_enable_ff(oe),
      .tune_start_ff(tune), .power_update_ff(pwr_up), .module_reset_ff(), .link_reset_ff(),
      .target_freq_ff(freq));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test;
      $display("compares %0d errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   function automatic logic [15:0] xs(input logic [15:0] v);
      v ^= v << 7;
      v ^= v >> 9;
      return v ^ (v << 8);
   endfunction
   // read monitor: each answer is matched with the oldest noted word
   always @(negedge clk) if (rvalid === 1'b1) chk(rdata, h.q.pop_front());
   initial begin
      #200_000;
      n_errors++;
      stop_test;
   end
   initial begin
      for (int m = 3; m >= 0; m--) begin
         arst_n = 0;
         pin_a = m[0];
         pin_b = m[1];
         repeat (4) @(negedge clk);
         arst_n = 1;
         repeat (2) @(negedge clk);
         h.rd(`TSC_OFS_CONFIG, {11'h000, ~m[0], 4'h2});
      end
      h.rd(`TSC_OFS_ALARM_TRIG, 16'h0404);
      h.rd(`TSC_OFS_FATAL_TRIG, 16'h000f);
      h.wr(`TSC_OFS_CHANNEL, 16'h0000);
      h.wr(`TSC_OFS_CHANNEL, 16'h0065);
      h.rd(`TSC_OFS_CHANNEL, 16'h0001);
      h.wr(`TSC_OFS_SPACING, 16'hfffe);
      h.wr(`TSC_OFS_FIRST_HI, 16'h00c2);
      h.wr(`TSC_OFS_FIRST_LO, 16'h06d6);
      h.wr(`TSC_OFS_CONFIG, 16'h001a);
      chk(tune, 1);
      @(negedge clk) chk(oe, 1);
      $display("defaults and enable done");
      repeat (3) begin
         rs = xs(rs);
         ch = rs % 100 + 1;
         h.wr(`TSC_OFS_CHANNEL, ch[15:0]);
         chk(tune, 1);
         repeat (2) @(negedge clk);
         ef = (ch - 1) * -2 + 1941750;
         chk(freq, ef);
         repeat (20) @(negedge clk);
      end
      chk(lock_n, 1);
      h.wr(`TSC_OFS_POWER_SET, 16'h0bb8);
      chk(pwr_up, 1);
      h.wr(`TSC_OFS_SPACING, 16'h0004);
      h.rd(`TSC_OFS_SPACING, 16'hfffe);
      h.wr(`TSC_OFS_FIRST_HI, 16'h00c3);
      h.rd(`TSC_OFS_FIRST_HI, 16'h00c2);
      $display("tuning done");
      fatal = 4'h4;
      @(negedge clk) fatal = 4'h0;
      repeat (2) @(negedge clk);
      chk(lock_n, 0);
      h.wr(`TSC_OFS_ALARM_TRIG, 16'h0000);
      @(negedge clk) chk(lock_n, 1);
      h.wr(`TSC_OFS_ALARM_TRIG, 16'h0404);
      h.wr(`TSC_OFS_STATUS_FATAL, 16'h0004);
      @(negedge clk) chk(lock_n, 1);
      hw_pin = 0;
      repeat (3) @(negedge clk);
      chk(oe, 0);
      hw_pin = 1;
      repeat (3) @(negedge clk);
      chk(oe, 0);
      h.wr(`TSC_OFS_CONFIG, 16'h001a);
      @(negedge clk) chk(oe, 1);
      h.wr(`TSC_OFS_CONFIG, 16'h0012);
      @(negedge clk) chk(oe, 0);
      @(negedge clk) chk(lock_n, 0);
      $display("alarm and enable done");
      sel = 0;
      @(negedge clk) sel = 1;
      h.wr(`TSC_OFS_RESET_CTL, 16'h0002);
      h.rd(`TSC_OFS_RESET_CTL, 16'h0000);
      h.wr(`TSC_OFS_RESET_CTL, 16'h0001);
      h.rd(`TSC_OFS_RESET_CTL, 16'h0000);
      repeat (2) @(negedge clk);
      $display("resets done");
      stop_test;
   end
endmodule // test_tsc_ctrl_regs
